// *** rtl/istix_top.sv ***
// Instruction set transition intercept unit with AXI4-Lite registers
`timescale 1ns/10ps
`include "istix_cfg.svh"
module istix_top
    import istix_pkg::*;
#(
    parameter int ADDR_W = `ISTIX_ADDR_W
) (
    input wire logic I_MCLK,
    input wire logic I_RST,
    input wire logic [ADDR_W-1:0] I_AWADDR,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    input wire logic I_WVALID,
    output logic O_WREADY,
    output logic [1:0] O_BRESP,
    output logic O_BVALID,
    input wire logic I_BREADY,
    input wire logic [ADDR_W-1:0] I_ARADDR,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_RVALID,
    input wire logic I_RREADY,
    output logic O_IRQ
);
    import istix_pkg::*;

    logic [ADDR_W-1:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;
    logic wr_go;
    logic [31:0] wmask;
    logic [31:0] ctrl;
    logic [31:0] num_stat;
    logic [31:0] num_ctrl;
    logic [31:0] num_ip;
    logic [31:0] num_dp;
    logic [31:0] instr_arg;
    logic low_fp_modified_flag;
    logic high_fp_modified_flag;
    logic legacy_interrupt_flag;
    logic first_legacy;
    istix_mode_type mode;
    logic [`ISTIX_EV_W-1:0] events;
    logic [`ISTIX_EV_W-1:0] ev_clear;
    logic [`ISTIX_EV_W-1:0] ev_status;
    logic [`ISTIX_EV_W-1:0] ev_mask;
    logic mask_we;
    logic enter_req;
    logic exit_req;
    logic instr_we;
    istix_op_type op;
    logic low_fp_disable_flag;
    logic high_fp_disable_flag;
    logic taken_branch_trap_enable;
    logic interrupt_intercept_enable;
    logic lock_check_disable;
    logic [31:0] rd_word;
    logic rd_ok;

    assign low_fp_disable_flag = ctrl[`ISTIX_CTRL_LOFP_DIS];
    assign high_fp_disable_flag = ctrl[`ISTIX_CTRL_HIFP_DIS];
    assign taken_branch_trap_enable = ctrl[`ISTIX_CTRL_TBT_EN];
    assign interrupt_intercept_enable = ctrl[`ISTIX_CTRL_INT_ICPT];
    assign lock_check_disable = ctrl[`ISTIX_CTRL_LOCK_CHK];

    // Write channel: address and data taken in either order
    assign O_AWREADY = !aw_held && !O_BVALID;
    assign O_WREADY = !w_held && !O_BVALID;
    assign wr_go = aw_held && w_held && !O_BVALID;

    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (I_AWVALID && O_AWREADY) begin
            aw_held <= 1'b1;
            aw_addr <= I_AWADDR;
        end else if (wr_go) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (I_WVALID && O_WREADY) begin
            w_held <= 1'b1;
            w_data <= I_WDATA;
            w_strb <= I_WSTRB;
        end else if (wr_go) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            O_BVALID <= 1'b0;
            O_BRESP <= `ISTIX_RESP_OKAY;
        end else if (wr_go) begin
            O_BVALID <= 1'b1;
            unique case (aw_addr)
                `ISTIX_OFF_CTRL, `ISTIX_OFF_IRQ_STAT, `ISTIX_OFF_IRQ_MASK,
                `ISTIX_OFF_NUM_STAT, `ISTIX_OFF_NUM_CTRL, `ISTIX_OFF_NUM_IP,
                `ISTIX_OFF_NUM_DP, `ISTIX_OFF_INSTR, `ISTIX_OFF_INSTR_ARG,
                `ISTIX_OFF_MODE: O_BRESP <= `ISTIX_RESP_OKAY;
                default: O_BRESP <= `ISTIX_RESP_SLVERR;
            endcase
        end else if (I_BREADY) begin
            O_BVALID <= 1'b0;
        end
    end

    always_comb begin
        wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    // Software-written registers; numeric state is the native home of legacy state
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            ctrl <= `ISTIX_CTRL_RST;
            num_stat <= '0;
            num_ctrl <= '0;
            num_ip <= '0;
            num_dp <= '0;
            instr_arg <= '0;
        end else if (wr_go) begin
            unique case (aw_addr)
                `ISTIX_OFF_CTRL: ctrl <= merge(ctrl, w_data, wmask);
                `ISTIX_OFF_NUM_STAT: num_stat <= merge(num_stat, w_data, wmask);
                `ISTIX_OFF_NUM_CTRL: num_ctrl <= merge(num_ctrl, w_data, wmask);
                `ISTIX_OFF_NUM_IP: num_ip <= merge(num_ip, w_data, wmask);
                `ISTIX_OFF_NUM_DP: num_dp <= merge(num_dp, w_data, wmask);
                `ISTIX_OFF_INSTR_ARG: instr_arg <= merge(instr_arg, w_data, wmask);
                default: ;
            endcase
        end
    end

    assign mask_we = wr_go && (aw_addr == `ISTIX_OFF_IRQ_MASK);
    assign ev_clear = (wr_go && aw_addr == `ISTIX_OFF_IRQ_STAT) ?
                      w_data[`ISTIX_EV_W-1:0] & wmask[`ISTIX_EV_W-1:0] : '0;
    assign instr_we = wr_go && (aw_addr == `ISTIX_OFF_INSTR) && (mode == ISTIX_LEGACY);
    assign op = istix_op_type'(w_data[`ISTIX_INSTR_OP_MSB:0]);
    assign enter_req = wr_go && (aw_addr == `ISTIX_OFF_MODE) && w_data[`ISTIX_MODE_ENTER]
                       && (mode == ISTIX_NATIVE);
    assign exit_req = wr_go && (aw_addr == `ISTIX_OFF_MODE) && !w_data[`ISTIX_MODE_ENTER]
                      && (mode == ISTIX_LEGACY);

    // Legacy exit and low FP modified flag (unless disabled in ctrl) updated on the same edge; high FP modified flag only holds its value
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            mode <= ISTIX_NATIVE;
            first_legacy <= 1'b0;
            low_fp_modified_flag <= 1'b0;
            high_fp_modified_flag <= 1'b0;
        end else begin
            if (enter_req) begin
                mode <= ISTIX_LEGACY;
                first_legacy <= 1'b1;
            end else if (exit_req) begin
                mode <= ISTIX_NATIVE;
                first_legacy <= 1'b0;
                if (!low_fp_disable_flag) begin
                    low_fp_modified_flag <= 1'b1;
                end
                high_fp_modified_flag <= high_fp_modified_flag;
            end else if (instr_we) begin
                first_legacy <= 1'b0;
            end
        end
    end

    // Legacy interrupt flag, cleared by the clear-interrupt instruction
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            legacy_interrupt_flag <= 1'b1;
        end else if (instr_we && op == ISTIX_OP_CLEAR_INT) begin
            legacy_interrupt_flag <= 1'b0;
        end else if (wr_go && aw_addr == `ISTIX_OFF_MODE && w_data[`ISTIX_MODE_SETIF]) begin
            legacy_interrupt_flag <= 1'b1;
        end
    end

    // Intercept decision per legacy instruction
    always_comb begin
        events = '0;
        events[`ISTIX_EV_EXIT] = exit_req;
        if (instr_we) begin
            if (first_legacy && high_fp_disable_flag) begin
                events[`ISTIX_EV_DISFP] = 1'b1;
            end else begin
                unique case (op)
                    ISTIX_OP_CALL: begin
                        events[`ISTIX_EV_GATE] = instr_arg[`ISTIX_ARG_GATE];
                        events[`ISTIX_EV_TBTRAP] = taken_branch_trap_enable;
                    end
                    ISTIX_OP_CLEAR_INT: events[`ISTIX_EV_SYSFLAG] =
                        legacy_interrupt_flag && interrupt_intercept_enable;
                    ISTIX_OP_CMP_EXCH: events[`ISTIX_EV_LOCK] =
                        lock_check_disable && instr_arg[`ISTIX_ARG_LOCKREQ];
                    default: ;
                endcase
            end
        end
    end

    istix_irq #(
        .W(`ISTIX_EV_W)
    ) u_irq (
        .i_clk(I_MCLK),
        .i_rst(I_RST),
        .i_event(events),
        .i_clear(ev_clear),
        .i_mask_we(mask_we),
        .i_mask_data(w_data[`ISTIX_EV_W-1:0]),
        .o_status(ev_status),
        .o_mask(ev_mask),
        .o_irq(O_IRQ)
    );

    // Read channel
    assign O_ARREADY = !O_RVALID;

    always_comb begin
        rd_word = '0;
        rd_ok = 1'b1;
        unique case (I_ARADDR)
            `ISTIX_OFF_CTRL: rd_word = ctrl;
            `ISTIX_OFF_STATE: begin
                rd_word[`ISTIX_ST_LOFP_MOD] = low_fp_modified_flag;
                rd_word[`ISTIX_ST_HIFP_MOD] = high_fp_modified_flag;
                rd_word[`ISTIX_ST_LEGACY] = (mode == ISTIX_LEGACY);
                rd_word[`ISTIX_ST_INT_FLAG] = legacy_interrupt_flag;
            end
            `ISTIX_OFF_IRQ_STAT: rd_word[`ISTIX_EV_W-1:0] = ev_status;
            `ISTIX_OFF_IRQ_MASK: rd_word[`ISTIX_EV_W-1:0] = ev_mask;
            `ISTIX_OFF_NUM_STAT: rd_word = num_stat;
            `ISTIX_OFF_NUM_CTRL: rd_word = num_ctrl;
            `ISTIX_OFF_NUM_IP: rd_word = num_ip;
            `ISTIX_OFF_NUM_DP: rd_word = num_dp;
            `ISTIX_OFF_INSTR_ARG: rd_word = instr_arg;
            `ISTIX_OFF_INSTR, `ISTIX_OFF_MODE: rd_word = '0;
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            O_RVALID <= 1'b0;
            O_RDATA <= '0;
            O_RRESP <= `ISTIX_RESP_OKAY;
        end else if (I_ARVALID && O_ARREADY) begin
            O_RVALID <= 1'b1;
            O_RDATA <= rd_word;
            O_RRESP <= rd_ok ? `ISTIX_RESP_OKAY : `ISTIX_RESP_SLVERR;
        end else if (I_RREADY) begin
            O_RVALID <= 1'b0;
        end
    end
endmodule

// *** rtl/istix_cfg.svh ***
// Constants for the instruction set transition intercept unit
`ifndef ISTIX_CFG_SVH
`define ISTIX_CFG_SVH
`define ISTIX_ADDR_W 8
`define ISTIX_OFF_CTRL 8'h00
`define ISTIX_OFF_STATE 8'h04
`define ISTIX_OFF_IRQ_STAT 8'h08
`define ISTIX_OFF_IRQ_MASK 8'h0C
`define ISTIX_OFF_NUM_STAT 8'h10
`define ISTIX_OFF_NUM_CTRL 8'h14
`define ISTIX_OFF_NUM_IP 8'h18
`define ISTIX_OFF_NUM_DP 8'h1C
`define ISTIX_OFF_INSTR 8'h20
`define ISTIX_OFF_INSTR_ARG 8'h24
`define ISTIX_OFF_MODE 8'h28
// Control register bits
`define ISTIX_CTRL_LOFP_DIS 0
`define ISTIX_CTRL_HIFP_DIS 1
`define ISTIX_CTRL_TBT_EN 2
`define ISTIX_CTRL_INT_ICPT 3
`define ISTIX_CTRL_LOCK_CHK 4
`define ISTIX_CTRL_RST 32'h0000_0001
// State register bits
`define ISTIX_ST_LOFP_MOD 0
`define ISTIX_ST_HIFP_MOD 1
`define ISTIX_ST_LEGACY 2
`define ISTIX_ST_INT_FLAG 3
// Mode register bits and instruction opcode field
`define ISTIX_MODE_ENTER 0
`define ISTIX_MODE_SETIF 1
`define ISTIX_INSTR_OP_MSB 3
// Event bits
`define ISTIX_EV_W 6
`define ISTIX_EV_GATE 0
`define ISTIX_EV_TBTRAP 1
`define ISTIX_EV_SYSFLAG 2
`define ISTIX_EV_LOCK 3
`define ISTIX_EV_DISFP 4
`define ISTIX_EV_EXIT 5
// Instruction argument bits and bus response codes
`define ISTIX_ARG_GATE 0
`define ISTIX_ARG_LOCKREQ 1
`define ISTIX_RESP_OKAY 2'h0
`define ISTIX_RESP_SLVERR 2'h2
`endif

// *** rtl/istix_pkg.sv ***
// Types for the instruction set transition intercept unit
package istix_pkg;
    typedef enum logic [3:0] {
        ISTIX_OP_NONE = 4'h0,
        ISTIX_OP_CALL = 4'h1,
        ISTIX_OP_CLEAR_INT = 4'h2,
        ISTIX_OP_CMP_EXCH = 4'h3,
        ISTIX_OP_OTHER = 4'h4
    } istix_op_type;
    typedef enum logic [1:0] {
        ISTIX_NATIVE = 2'b01,
        ISTIX_LEGACY = 2'b10
    } istix_mode_type;
endpackage

// *** rtl/istix_irq.sv ***
// Sticky event status with mask and level interrupt
`timescale 1ns/10ps
`include "istix_cfg.svh"
module istix_irq #(
    parameter int W = `ISTIX_EV_W
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_event,
    input wire logic [W-1:0] i_clear,
    input wire logic i_mask_we,
    input wire logic [W-1:0] i_mask_data,
    output logic [W-1:0] o_status,
    output logic [W-1:0] o_mask,
    output logic o_irq
);
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            // Set wins over a same-cycle clear
            always_ff @(posedge i_clk or posedge i_rst) begin
                if (i_rst) begin
                    o_status[g] <= 1'b0;
                end else if (i_event[g]) begin
                    o_status[g] <= 1'b1;
                end else if (i_clear[g]) begin
                    o_status[g] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_mask <= '0;
        end else if (i_mask_we) begin
            o_mask <= i_mask_data;
        end
    end

    assign o_irq = |(o_status & o_mask);
endmodule

// *** verif/istix_top_asserts.sv ***
// Bus handshake checker for the transition intercept unit
`timescale 1ns/10ps
`include "istix_cfg.svh"
module istix_top_asserts #(
    parameter int ADDR_W = 8
) (
    input wire logic I_MCLK,
    input wire logic I_RST,
    input wire logic I_AWVALID,
    input wire logic O_AWREADY,
    input wire logic I_WVALID,
    input wire logic O_WREADY,
    input wire logic [1:0] O_BRESP,
    input wire logic O_BVALID,
    input wire logic I_BREADY,
    input wire logic I_ARVALID,
    input wire logic O_ARREADY,
    input wire logic [31:0] O_RDATA,
    input wire logic [1:0] O_RRESP,
    input wire logic O_RVALID,
    input wire logic I_RREADY
);
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (I_RST);
    bresp_hold_a: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
        else $error("write response dropped early");
    rdata_hold_a: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
        else $error("read data dropped early");
    bvalid_drop_a: assert property (O_BVALID && I_BREADY |=> !O_BVALID)
        else $error("write response not retired");
    rvalid_drop_a: assert property (O_RVALID && I_RREADY |=> !O_RVALID)
        else $error("read data not retired");
    read_answer_a: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
        else $error("read answer late");
    write_answer_a: assert property
        (I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##[1:3] O_BVALID)
        else $error("write answer late");
    busy_block_a: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
        else $error("write accepted while response pending");
    ar_gate_a: assert property (O_ARREADY == !O_RVALID)
        else $error("read ready wrong");
    err_data_a: assert property (O_RVALID && O_RRESP == `ISTIX_RESP_SLVERR |-> O_RDATA == 32'h0)
        else $error("error read carries data");
endmodule

bind istix_top istix_top_asserts #(.ADDR_W(ADDR_W)) i_istix_top_asserts (
    .I_MCLK(I_MCLK), .I_RST(I_RST), .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY),
    .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BRESP(O_BRESP), .O_BVALID(O_BVALID),
    .I_BREADY(I_BREADY), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA),
    .O_RRESP(O_RRESP), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY));

// *** verif/tb_isa_transition_state_intercept.sv ***
// Register-level testbench for the transition intercept unit
`timescale 1ns/10ps
`include "istix_cfg.svh"
module tb_isa_transition_state_intercept;
    import istix_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [31:0] v;
    logic [3:0] strb = 4'hF;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, resp;
    int fails = 0, n_checks = 0;
    always #4 clk = ~clk;
    istix_top i_istix_top (.I_MCLK(clk), .I_RST(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
        .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(strb), .I_WVALID(wvalid),
        .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
        .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
        .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .O_IRQ(irq));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ad;
        logic wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd)) begin
            @(negedge clk);
            ad = ad || awready;
            wd = wd || wready;
            @(posedge clk);
            if (ad) begin
                awvalid <= 1'b0;
            end
            if (wd) begin
                wvalid <= 1'b0;
            end
        end
        do @(negedge clk); while (!bvalid);
        resp = bresp;
        @(posedge clk);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge clk); while (!arready);
        @(posedge clk);
        arvalid <= 1'b0;
        do @(negedge clk); while (!rvalid);
        v = rdata;
        resp = rresp;
        @(posedge clk);
        rready <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        check(v, exp);
        check({30'h0, resp}, {30'h0, `ISTIX_RESP_OKAY});
    endtask
    // Read events, then clear them all
    task automatic stat(input logic [31:0] exp);
        rchk(`ISTIX_OFF_IRQ_STAT, exp);
        wr(`ISTIX_OFF_IRQ_STAT, 32'h3F);
    endtask
    task automatic op(input logic [31:0] arg, input istix_op_type o);
        wr(`ISTIX_OFF_INSTR_ARG, arg);
        wr(`ISTIX_OFF_INSTR, {28'h0, o});
    endtask
    task automatic conclude;
        if (fails == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #200000;
        fails++;
        conclude;
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 0;
        rchk(`ISTIX_OFF_CTRL, 32'h1);
        rchk(`ISTIX_OFF_STATE, 32'h8);
        rchk(`ISTIX_OFF_IRQ_MASK, 32'h0);
        rd(8'h40);
        check(v, 32'h0);
        check({30'h0, resp}, {30'h0, `ISTIX_RESP_SLVERR});
        wr(8'h40, 32'h5);
        check({30'h0, resp}, {30'h0, `ISTIX_RESP_SLVERR});
        for (int i = 0; i < 4; i++) begin
            wr(`ISTIX_OFF_NUM_STAT + 8'(4 * i), 32'hA5C3_0F00 + i);
        end
        wr(`ISTIX_OFF_CTRL, 32'h4);
        op(32'h1, ISTIX_OP_CALL);
        stat(32'h0);
        wr(`ISTIX_OFF_CTRL, 32'h1);
        wr(`ISTIX_OFF_MODE, 32'h1);
        wr(`ISTIX_OFF_MODE, 32'h0);
        rchk(`ISTIX_OFF_STATE, 32'h8);
        stat(32'h20);
        wr(`ISTIX_OFF_CTRL, 32'h3);
        wr(`ISTIX_OFF_MODE, 32'h1);
        op(32'h0, ISTIX_OP_OTHER);
        check({31'h0, irq}, 32'h0);
        stat(32'h10);
        op(32'h0, ISTIX_OP_OTHER);
        stat(32'h0);
        wr(`ISTIX_OFF_MODE, 32'h0);
        stat(32'h20);
        wr(`ISTIX_OFF_CTRL, 32'h1C);
        wr(`ISTIX_OFF_MODE, 32'h1);
        rchk(`ISTIX_OFF_STATE, 32'hC);
        for (int i = 0; i < 4; i++) begin
            rchk(`ISTIX_OFF_NUM_STAT + 8'(4 * i), 32'hA5C3_0F00 + i);
        end
        op(32'h1, ISTIX_OP_CALL);
        stat(32'h3);
        op(32'h0, ISTIX_OP_CALL);
        stat(32'h2);
        op(32'h2, ISTIX_OP_CMP_EXCH);
        stat(32'h8);
        op(32'h0, ISTIX_OP_CMP_EXCH);
        stat(32'h0);
        op(32'h3, ISTIX_OP_OTHER);
        stat(32'h0);
        op(32'h0, ISTIX_OP_CLEAR_INT);
        stat(32'h4);
        op(32'h0, ISTIX_OP_CLEAR_INT);
        stat(32'h0);
        wr(`ISTIX_OFF_NUM_CTRL, 32'h0000_037F);
        wr(`ISTIX_OFF_IRQ_MASK, 32'h3F);
        op(32'h1, ISTIX_OP_CALL);
        @(negedge clk);
        check({31'h0, irq}, 32'h1);
        stat(32'h3);
        @(negedge clk);
        check({31'h0, irq}, 32'h0);
        wr(`ISTIX_OFF_MODE, 32'h0);
        rd(`ISTIX_OFF_STATE);
        check(v & 32'h7, 32'h1);
        check(v & 32'h1, 32'h1);
        rchk(`ISTIX_OFF_NUM_CTRL, 32'h0000_037F);
        strb <= 4'h2;
        wr(`ISTIX_OFF_NUM_DP, 32'h0000_5A00);
        strb <= 4'hF;
        rchk(`ISTIX_OFF_NUM_DP, 32'hA5C3_5A03);
        wr(`ISTIX_OFF_CTRL, 32'h0);
        wr(`ISTIX_OFF_MODE, 32'h1);
        wr(`ISTIX_OFF_MODE, 32'h3);
        rchk(`ISTIX_OFF_STATE, 32'hD);
        op(32'h0, ISTIX_OP_CLEAR_INT);
        op(32'h3, ISTIX_OP_CMP_EXCH);
        stat(32'h20);
        op(32'h3, ISTIX_OP_CALL);
        stat(32'h1);
        wr(`ISTIX_OFF_MODE, 32'h0);
        stat(32'h20);
        conclude;
    end
endmodule
